// [hw/dfca_pkg.sv]
// shared constants and types for the diode fault / consecutive alert block
package dfca_pkg;
   localparam int NCH  = 5;
   localparam int NEXT = 4;

   localparam logic [7:0] ADDR_CONSEC = 8'h22;
   localparam logic [7:0] ADDR_IDEAL0 = 8'h30;
   localparam logic [7:0] ADDR_CFG    = 8'h50;
   localparam logic [7:0] ADDR_CHEN   = 8'h51;
   localparam logic [7:0] ADDR_AMASK  = 8'h52;
   localparam logic [7:0] ADDR_HIST   = 8'h53;
   localparam logic [7:0] ADDR_LOST   = 8'h54;
   localparam logic [7:0] ADDR_FLST   = 8'h55;
   localparam logic [7:0] ADDR_THST   = 8'h56;

   localparam int ALRT_LSB = 0;
   localparam int THRM_LSB = 4;
   localparam int CFG_COMP = 0;

   localparam logic [7:0] CONSEC_RST = 8'h70;
   localparam logic [7:0] CFG_RST    = 8'h00;
   localparam logic [4:0] CHEN_RST   = 5'h1F;
   localparam logic [4:0] AMASK_RST  = 5'h00;
   localparam logic [5:0] IDEAL_RST  = 6'h12;
   localparam logic [5:0] IDEAL_MIN  = 6'h08;
   localparam logic [5:0] IDEAL_MAX  = 6'h37;

   // factors in units of 0.0001, stored as offsets from the lowest code
   localparam logic [15:0] FACTOR_BASE = 16'h26DD;
   localparam logic [15:0] BJT_SHIFT   = 16'h0050;
   localparam logic [9:0] IDEAL_OFS [48] = '{
      10'h000, 10'h00D, 10'h01A, 10'h027, 10'h034, 10'h041, 10'h04E, 10'h05B,
      10'h068, 10'h075, 10'h083, 10'h090, 10'h09D, 10'h0AA, 10'h0B8, 10'h0C5,
      10'h0D2, 10'h0DF, 10'h0EC, 10'h0FB, 10'h107, 10'h115, 10'h122, 10'h130,
      10'h13E, 10'h14B, 10'h158, 10'h165, 10'h172, 10'h17F, 10'h18C, 10'h199,
      10'h1A6, 10'h1B3, 10'h1C0, 10'h1CD, 10'h1DA, 10'h1E7, 10'h1F4, 10'h201,
      10'h20E, 10'h21B, 10'h228, 10'h235, 10'h242, 10'h24F, 10'h25C, 10'h269};

   typedef struct packed {
      logic [7:0] temp;
      logic [7:0] high_lim;
      logic [7:0] low_lim;
      logic [7:0] therm_lim;
   } dfca_ch_in_type;

   typedef struct packed {
      logic open;
      logic vdd_anode;
      logic vdd_cathode;
      logic anode_cathode;
      logic anode_gnd;
      logic cathode_gnd;
   } dfca_raw_type;

   typedef struct packed {
      logic trig;
      logic hi;
      logic lo;
      logic flt;
   } dfca_ev_type;

   function automatic logic consec_valid(input logic [2:0] c);
      return (c == 3'h0) || (c == 3'h1) || (c == 3'h3) || (c == 3'h7);
   endfunction

   function automatic logic [2:0] consec_count(input logic [2:0] c);
      case (c)
         3'h1:    return 3'h2;
         3'h3:    return 3'h3;
         3'h7:    return 3'h4;
         default: return 3'h1;
      endcase
   endfunction
endpackage

// [hw/dfca_chan.sv]
// per-channel limit compare and consecutive counters for both pins
module dfca_chan
   import dfca_pkg::*;
(
   input  wire logic           clk_i,
   input  wire logic           rst_i,
   input  wire logic           meas_i,
   input  wire logic           en_i,
   input  wire logic           comp_mode_i,
   input  wire dfca_ch_in_type in_i,
   input  wire logic [7:0]     hyst_i,
   input  wire logic           fault_i,
   input  wire logic [2:0]     alert_tgt_i,
   input  wire logic [2:0]     therm_tgt_i,
   output dfca_ev_type         ev_o,
   output logic                comp_hold_o,
   output logic                therm_hold_o
);
   typedef struct packed {
      logic [2:0]  acnt;
      logic [2:0]  tcnt;
      logic        chold;
      logic        thold;
      dfca_ev_type ev;
   } dfca_chst_type;

   dfca_chst_type s_q;
   dfca_chst_type s_d;
   logic          hi;
   logic          lo;
   logic          hi_rel;
   logic          th_ex;
   logic          th_rel;

   always_comb begin
      // a faulted result reads zero, so the high and low limits are not judged on it; the overtemp limit still is
      hi     = !fault_i && (in_i.temp > in_i.high_lim);
      lo     = !fault_i && (in_i.temp < in_i.low_lim); // R3
      hi_rel = ({1'b0, in_i.temp} + {1'b0, hyst_i}) < {1'b0, in_i.high_lim};
      th_ex  = in_i.temp > in_i.therm_lim;
      th_rel = ({1'b0, in_i.temp} + {1'b0, hyst_i}) < {1'b0, in_i.therm_lim};
      s_d    = s_q;
      s_d.ev = '0;
      if (!en_i) begin
         s_d.acnt  = 3'h0; // R12
         s_d.tcnt  = 3'h0;
         s_d.chold = 1'b0;
         s_d.thold = 1'b0;
      end else if (meas_i) begin
         // while enabled, counters move only on the measurement strobe, which all channels share
         if (!comp_mode_i) begin
            s_d.chold = 1'b0;
            if (hi || lo || fault_i) begin // R7
               if (3'(s_q.acnt + 3'h1) == alert_tgt_i) begin
                  s_d.ev.trig = 1'b1; // R8
                  s_d.ev.hi   = hi;
                  s_d.ev.lo   = lo;
                  s_d.ev.flt  = fault_i;
                  s_d.acnt    = 3'h0;
               end else begin
                  s_d.acnt = 3'(s_q.acnt + 3'h1);
               end
            end else begin
               s_d.acnt = 3'h0; // R7
            end
         end else begin
            s_d.ev.lo  = lo; // R11
            s_d.ev.flt = fault_i; // R11
            if (s_q.chold) begin
               if (hi_rel) begin // R10
                  s_d.chold = 1'b0;
                  s_d.acnt  = 3'h0;
               end
            end else if (hi) begin // R10
               if (3'(s_q.acnt + 3'h1) == alert_tgt_i) begin
                  s_d.chold = 1'b1;
                  s_d.ev.hi = 1'b1;
               end else begin
                  s_d.acnt = 3'(s_q.acnt + 3'h1);
               end
            end else begin
               s_d.acnt = 3'h0;
            end
         end
         if (s_q.thold) begin
            if (th_rel) begin // R14
               s_d.thold = 1'b0;
               s_d.tcnt  = 3'h0;
            end
         end else if (th_ex) begin // R13
            if (3'(s_q.tcnt + 3'h1) == therm_tgt_i) begin
               s_d.thold = 1'b1;
            end else begin
               s_d.tcnt = 3'(s_q.tcnt + 3'h1);
            end
         end else begin
            s_d.tcnt = 3'h0; // R13
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign ev_o         = s_q.ev;
   assign comp_hold_o  = s_q.chold;
   assign therm_hold_o = s_q.thold;
endmodule

// [hw/dfca_top.sv]
// alert qualification, diode fault handling and ideality settings
// Summary of operation
// [R1] per-diode 6-bit ideality code, 12h is 1.0080
// [R2] substrate transistor model shifts table, 12h 1.0000
// [R3] open or supply short forces zero, alerts
// [R4] anode shorts read zero, no fault, no alert
// [R5] cathode-to-ground short leaves measurement untouched
// [R6] separate counters per channel, shared targets
// [R7] high, low or fault counts; clean resets
// [R8] interrupt trigger sets status, alerts, clears counter
// [R9] other channels' counters hold on a trigger
// [R10] comparator counts high only, holds until hysteresis
// [R11] comparator low and fault set status only
// [R12] disabled channels skip; limit-counter-status-mask-pin order
// [R13] overtemp counter counts exceedances, drives pin low
// [R14] overtemp counter held until below hysteresis
// [R15] reset: overtemp count four, alert count one
// [R16] invalid consecutive-count writes are ignored
// [R17] codes 000,001,011,111 mean one to four
// [R18] mask blocks pin only, status still updates
module dfca_top
   import dfca_pkg::*;
(
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   input  wire logic [7:0]                 reg_addr_i,
   input  wire logic [7:0]                 reg_wdata_i,
   output logic      [7:0]                 reg_rdata_o,
   input  wire logic                       meas_done_i,
   input  wire dfca_ch_in_type [NCH-1:0]   ch_in_i,
   input  wire logic [7:0]                 hyst_i,
   input  wire dfca_raw_type [NEXT-1:0]    diode_raw_i,
   input  wire logic [NEXT-1:0]            bjt_model_i,
   output logic      [NCH-1:0][7:0]        result_o,
   output logic      [NEXT-1:0][15:0]      ideal_factor_o,
   output logic                            alert_n_o,
   output logic                            therm_n_o
);
   typedef struct packed {
      logic [7:0]                  consec;
      logic [7:0]                  cfg;
      logic [NCH-1:0]              chen;
      logic [NCH-1:0]              amask;
      logic [NEXT-1:0][5:0]        ideal;
      logic [NCH-1:0]              hi_st;
      logic [NCH-1:0]              lo_st;
      logic [NCH-1:0]              fl_st;
      dfca_raw_type [NEXT-1:0]     sync1;
      dfca_raw_type [NEXT-1:0]     sync2;
      logic [NCH-1:0][7:0]         result;
      logic [NEXT-1:0][15:0]       factor;
      logic [7:0]                  rdata;
      logic                        alert;
      logic                        therm;
   } dfca_state_type;

   dfca_state_type      s_q;
   dfca_state_type      s_d;
   logic [NCH-1:0]      fault;
   dfca_ev_type [NCH-1:0] ev;
   logic [NCH-1:0]      comp_hold;
   logic [NCH-1:0]      therm_hold;
   logic                comp_mode;
   logic [2:0]          alert_tgt;
   logic [2:0]          therm_tgt;
   dfca_ch_in_type [NCH-1:0] ch_eff;

   assign comp_mode = s_q.cfg[CFG_COMP];
   assign alert_tgt = consec_count(s_q.consec[ALRT_LSB +: 3]); // R17
   assign therm_tgt = consec_count(s_q.consec[THRM_LSB +: 3]); // R17

   // the internal channel has no external junction to fault
   assign fault[0] = 1'b0;

   // an anode short reads as zero degrees, which must not pass for a low reading
   always_comb begin
      ch_eff = ch_in_i;
      for (int e = 0; e < NEXT; e++) begin
         if (s_q.sync2[e].anode_cathode || s_q.sync2[e].anode_gnd) begin
            ch_eff[e+1].low_lim = 8'h00; // R4
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NEXT; gi++) begin : g_flt
         // shorts to the anode read as a zero reading, not a fault
         assign fault[gi+1] = s_q.sync2[gi].open // R3
                            | s_q.sync2[gi].vdd_anode
                            | s_q.sync2[gi].vdd_cathode; // R4 R5
      end

      for (gi = 0; gi < NCH; gi++) begin : g_ch
         dfca_chan u_chan (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .meas_i      (meas_done_i),
            .en_i        (s_q.chen[gi]),
            .comp_mode_i (comp_mode),
            .in_i        (ch_eff[gi]),
            .hyst_i      (hyst_i),
            .fault_i     (fault[gi]),
            .alert_tgt_i (alert_tgt),
            .therm_tgt_i (therm_tgt),
            .ev_o        (ev[gi]),
            .comp_hold_o (comp_hold[gi]),
            .therm_hold_o(therm_hold[gi])
         ); // R6 R9
      end
   endgenerate

   function automatic logic [15:0] lookup(input logic [5:0] code,
                                          input logic       bjt);
      logic [15:0] f;
      f = 16'h0000;
      // codes outside the table give zero so software can spot them
      if (code >= IDEAL_MIN && code <= IDEAL_MAX) begin
         f = FACTOR_BASE + {6'h00, IDEAL_OFS[6'(code - IDEAL_MIN)]}; // R1
         if (bjt) begin
            f = f - BJT_SHIFT; // R2
         end
      end
      return f;
   endfunction

   always_comb begin
      logic [NCH-1:0] rd_hi;
      logic [NCH-1:0] rd_lo;
      logic [NCH-1:0] rd_fl;
      logic [NCH-1:0] set_hi;
      logic [NCH-1:0] set_lo;
      logic [NCH-1:0] set_fl;
      logic [7:0]     rd;
      rd_hi  = '0;
      rd_lo  = '0;
      rd_fl  = '0;
      set_hi = '0;
      set_lo = '0;
      set_fl = '0;
      rd     = 8'h00;
      s_d    = s_q;

      s_d.sync1 = diode_raw_i;
      s_d.sync2 = s_q.sync1;

      for (int c = 0; c < NCH; c++) begin
         set_hi[c] = ev[c].hi;
         set_lo[c] = ev[c].lo;
         set_fl[c] = ev[c].flt;
         if (meas_done_i) begin
            s_d.result[c] = fault[c] ? 8'h00 : ch_in_i[c].temp; // R3
         end
      end

      if (reg_wr_i) begin
         case (reg_addr_i)
            ADDR_CONSEC: begin
               if (consec_valid(reg_wdata_i[ALRT_LSB +: 3]) &&
                   consec_valid(reg_wdata_i[THRM_LSB +: 3])) begin
                  s_d.consec = reg_wdata_i; // R16
               end
            end
            ADDR_CFG:   s_d.cfg   = reg_wdata_i;
            ADDR_CHEN:  s_d.chen  = reg_wdata_i[NCH-1:0];
            ADDR_AMASK: s_d.amask = reg_wdata_i[NCH-1:0];
            default: begin
               for (int d = 0; d < NEXT; d++) begin
                  if (reg_addr_i == 8'(ADDR_IDEAL0 + 8'(d))) begin
                     s_d.ideal[d] = reg_wdata_i[5:0]; // R1
                  end
               end
            end
         endcase
      end

      if (reg_rd_i) begin
         case (reg_addr_i)
            ADDR_CONSEC: rd = s_q.consec;
            ADDR_CFG:    rd = s_q.cfg;
            ADDR_CHEN:   rd = {3'h0, s_q.chen};
            ADDR_AMASK:  rd = {3'h0, s_q.amask};
            ADDR_HIST: begin
               rd    = {3'h0, s_q.hi_st};
               rd_hi = '1;
            end
            ADDR_LOST: begin
               rd    = {3'h0, s_q.lo_st};
               rd_lo = '1;
            end
            ADDR_FLST: begin
               rd    = {3'h0, s_q.fl_st};
               rd_fl = '1;
            end
            ADDR_THST:   rd = {3'h0, therm_hold};
            default: begin
               for (int d = 0; d < NEXT; d++) begin
                  if (reg_addr_i == 8'(ADDR_IDEAL0 + 8'(d))) begin
                     rd = {2'h0, s_q.ideal[d]};
                  end
               end
            end
         endcase
         s_d.rdata = rd;
      end

      // read clears status, but a same-cycle event wins
      s_d.hi_st = (s_q.hi_st & ~rd_hi) | set_hi; // R8 R18
      s_d.lo_st = (s_q.lo_st & ~rd_lo) | set_lo; // R11 R18
      s_d.fl_st = (s_q.fl_st & ~rd_fl) | set_fl; // R11 R18

      for (int d = 0; d < NEXT; d++) begin
         s_d.factor[d] = lookup(s_q.ideal[d], bjt_model_i[d]); // R1 R2
      end

      // the mask sits after status, or after the comparator hold in comparator mode, and before the pin
      if (comp_mode) begin
         s_d.alert = |(comp_hold & ~s_q.amask); // R10 R11 R12 R18
      end else begin
         s_d.alert = |((s_q.hi_st | s_q.lo_st | s_q.fl_st)
                       & ~s_q.amask); // R8 R12 R18
      end
      s_d.therm = |therm_hold; // R13 R14
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q        <= '0;
         s_q.consec <= CONSEC_RST; // R15
         s_q.cfg    <= CFG_RST;
         s_q.chen   <= CHEN_RST;
         s_q.amask  <= AMASK_RST;
         s_q.ideal  <= {NEXT{IDEAL_RST}}; // R1
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_o    = s_q.rdata;
   assign result_o       = s_q.result;
   assign ideal_factor_o = s_q.factor;
   assign alert_n_o      = ~s_q.alert;
   assign therm_n_o      = ~s_q.therm; // R13
endmodule

// [bench/dfca_diode_model.sv]
// external diode model: fault kind to raw detector levels and reading
module dfca_diode_model
   import dfca_pkg::*;
(
   input  wire logic [2:0] kind_i,
   input  wire logic [7:0] temp_i,
   output dfca_raw_type    raw_o,
   output logic      [7:0] temp_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // kinds: 0 clean, 1 open, 2 supply-anode, 3 supply-cathode,
   // 4 anode-cathode, 5 anode-ground, 6 cathode-ground
   always_comb begin
      raw_o = '0;
      raw_o.open = (kind_i == 3'h1);
      raw_o.vdd_anode = (kind_i == 3'h2);
      raw_o.vdd_cathode = (kind_i == 3'h3);
      raw_o.anode_cathode = (kind_i == 3'h4);
      raw_o.anode_gnd = (kind_i == 3'h5);
      raw_o.cathode_gnd = (kind_i == 3'h6);
      // a broken diode converts to junk, so the block must do the zeroing
      temp_o = (kind_i inside {3'h1, 3'h2, 3'h3}) ? 8'hFF : temp_i;
      if (kind_i inside {3'h4, 3'h5})
         temp_o = 8'h00;
   end
endmodule

// [bench/dfca_top_chk.sv]
// assertions on the alert qualification block ports
module dfca_top_chk
   import dfca_pkg::*;
(
   input wire logic                     clk_i,
   input wire logic                     rst_i,
   input wire logic                     reg_wr_i,
   input wire logic                     reg_rd_i,
   input wire logic                     meas_done_i,
   input wire dfca_ch_in_type [NCH-1:0] ch_in_i,
   input wire dfca_raw_type [NEXT-1:0]  diode_raw_i,
   input wire logic [NCH-1:0][7:0]      result_o,
   input wire logic [NEXT-1:0][15:0]    ideal_factor_o,
   input wire logic                     alert_n_o,
   input wire logic                     therm_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // raw levels pass a synchroniser, so only settled levels count
   sequence open_meas;
      meas_done_i && diode_raw_i[0].open && $past(diode_raw_i[0].open, 3);
   endsequence
   sequence short_meas;
      meas_done_i && diode_raw_i[0].anode_cathode && $past(diode_raw_i[0].anode_cathode, 3);
   endsequence
   sequence gnd_meas;
      meas_done_i && diode_raw_i[0] == 6'h01 && $past(diode_raw_i[0], 3) == 6'h01;
   endsequence
   a_fault_zeroes: assert property (open_meas |=> result_o[1] == 8'h00)
      else $error("faulted channel result not zero");
   a_short_zeroes: assert property (short_meas |=> result_o[1] == 8'h00)
      else $error("shorted channel result not zero");
   a_gnd_short_normal: assert property (gnd_meas |=> result_o[1] == $past(ch_in_i[1].temp))
      else $error("cathode short altered the result");
   a_therm_fall: assert property ($fell(therm_n_o) |-> $past(meas_done_i, 2))
      else $error("overtemp pin fell without a measurement");
   a_therm_rise: assert property ($rose(therm_n_o) |-> $past(meas_done_i, 2) || $past(reg_wr_i, 2)
      || $past(reg_wr_i, 3))
      else $error("overtemp pin released off schedule");
   a_alert_fall: assert property ($fell(alert_n_o) |-> $past(meas_done_i, 3) || $past(reg_wr_i, 1)
      || $past(reg_wr_i, 2) || $past(reg_wr_i, 3)
      || $past(meas_done_i, 2))
      else $error("alert pin fell without a cause");
   a_alert_rise: assert property ($rose(alert_n_o) |-> $past(meas_done_i, 3) || $past(reg_rd_i, 2)
      || $past(reg_wr_i, 1) || $past(reg_wr_i, 2) || $past(reg_wr_i, 3)
      || $past(meas_done_i, 2))
      else $error("alert pin released without a cause");
   a_factor_range: assert property (ideal_factor_o[0] == 16'h0000 ||
      (ideal_factor_o[0] >= 16'h268D && ideal_factor_o[0] <= 16'h2946))
      else $error("ideality factor outside both tables");
endmodule

bind dfca_top dfca_top_chk i_dfca_top_chk (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .meas_done_i(meas_done_i), .ch_in_i(ch_in_i), .diode_raw_i(diode_raw_i),
   .result_o(result_o), .ideal_factor_o(ideal_factor_o), .alert_n_o(alert_n_o),
   .therm_n_o(therm_n_o));

// [bench/dfca_top_test.sv]
// self-checking bench for the alert qualification block
module dfca_top_test
   import dfca_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, wr, rd, meas, alert_n, therm_n;
   logic [7:0]                addr, wdata, rdata, hyst, temp1, pt_temp, d;
   logic [2:0]                kind;
   logic [NEXT-1:0]           bjt;
   dfca_ch_in_type [NCH-1:0]  ch_in, ch_drv;
   dfca_raw_type              raw;
   logic [NCH-1:0][7:0]       res;
   logic [NEXT-1:0][15:0]     fac;
   int                        num_errors, checked;
   // kind, temp, result, alert_n, high, low, fault
   localparam logic [23:0] ROWS [9] = '{24'h032328, 24'h050504, 24'h005052, 24'h132001,
      24'h232001, 24'h332001, 24'h432008, 24'h532008, 24'h632328};
   localparam logic [5:0] CODES [3] = '{6'h12, 6'h08, 6'h37};
   localparam logic [15:0] FDIO [3] = '{16'h2760, 16'h26DD, 16'h2946};
   localparam logic [15:0] FBJT [3] = '{16'h2710, 16'h268D, 16'h28F6};
   always_comb begin
      ch_drv = ch_in;
      ch_drv[1].temp = pt_temp;
   end
   dfca_diode_model i_dfca_diode_model (.kind_i(kind), .temp_i(temp1), .raw_o(raw),
      .temp_o(pt_temp));
   dfca_top i_dfca_top (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .meas_done_i(meas),
      .ch_in_i(ch_drv), .hyst_i(hyst), .diode_raw_i({18'h0, raw}), .bjt_model_i(bjt),
      .result_o(res), .ideal_factor_o(fac), .alert_n_o(alert_n), .therm_n_o(therm_n));
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk_i);
      wr = 1'b1; addr = a; wdata = v;
      @(negedge clk_i);
      wr = 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_i);
      rd = 1'b1; addr = a;
      @(negedge clk_i);
      rd = 1'b0;
      chk("register", rdata, exp);
   endtask
   // inputs settle through the synchroniser first, then one pulse, then the pin delay
   task automatic measure();
      repeat (3) @(negedge clk_i);
      meas = 1'b1;
      @(negedge clk_i);
      meas = 1'b0;
      repeat (3) @(negedge clk_i);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      conclude();
   end
   initial begin
      num_errors = 0; checked = 0; rst_i = 1'b1; wr = 1'b0; rd = 1'b0; meas = 1'b0;
      addr = 8'h00; wdata = 8'h00; hyst = 8'h0A; kind = 3'h0; temp1 = 8'h32; bjt = '0;
      for (int c = 0; c < NCH; c++)
         ch_in[c] = '{8'h32, 8'h46, 8'h0A, 8'h55};
      repeat (12) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (2) @(negedge clk_i);
      for (int r = 0; r < 9; r++) begin
         kind = ROWS[r][22:20];
         temp1 = ROWS[r][19:12];
         measure();
         chk("result", res[1], ROWS[r][11:4]);
         chk("alert", alert_n, ROWS[r][3]);
         rd_chk(ADDR_HIST, {6'h0, ROWS[r][2], 1'b0});
         rd_chk(ADDR_LOST, {6'h0, ROWS[r][1], 1'b0});
         rd_chk(ADDR_FLST, {6'h0, ROWS[r][0], 1'b0});
         repeat (4) @(negedge clk_i);
         chk("alert release", alert_n, 1'b1);
      end
      kind = 3'h0;
      temp1 = 8'h32;
      rd_chk(ADDR_CONSEC, 8'h70);
      rd_chk(ADDR_IDEAL0, 8'h12);
      for (int i = 0; i < 3; i++) begin
         wr_reg(ADDR_IDEAL0, {2'h0, CODES[i]});
         @(negedge clk_i);
         chk("factor", fac[0], FDIO[i]);
         bjt[0] = 1'b1;
         repeat (2) @(negedge clk_i);
         chk("bjt factor", fac[0], FBJT[i]);
         bjt[0] = 1'b0;
      end
      for (int j = 0; j < 4; j++) begin
         d = {1'b0, 3'h7 >> (3 - j), 1'b0, 3'h7 >> (3 - j)};
         wr_reg(ADDR_CONSEC, d);
         rd_chk(ADDR_CONSEC, d);
      end
      wr_reg(ADDR_CONSEC, 8'h72);
      wr_reg(ADDR_CONSEC, 8'h25);
      rd_chk(ADDR_CONSEC, 8'h77);
      wr_reg(ADDR_CONSEC, 8'h71);
      temp1 = 8'h50;
      measure();
      chk("alert count two", alert_n, 1'b1);
      measure();
      chk("alert count two", alert_n, 1'b0);
      rd_chk(ADDR_HIST, 8'h02);
      measure();
      ch_in[2].temp = 8'h50;
      measure();
      rd_chk(ADDR_HIST, 8'h02);
      temp1 = 8'h32;
      measure();
      rd_chk(ADDR_HIST, 8'h04);
      ch_in[2].temp = 8'h32;
      temp1 = 8'h50;
      wr_reg(ADDR_CONSEC, 8'h70);
      wr_reg(ADDR_AMASK, 8'h02);
      measure();
      chk("masked alert", alert_n, 1'b1);
      rd_chk(ADDR_HIST, 8'h02);
      wr_reg(ADDR_AMASK, 8'h00);
      wr_reg(ADDR_CHEN, 8'h1D);
      measure();
      chk("disabled alert", alert_n, 1'b1);
      rd_chk(ADDR_HIST, 8'h00);
      wr_reg(ADDR_CHEN, 8'h1F);
      ch_in[2] = '{8'h60, 8'hFF, 8'h0A, 8'h55};
      temp1 = 8'h32;
      for (int k = 0; k < 4; k++) begin
         measure();
         chk("overtemp", therm_n, k < 3);
      end
      ch_in[2].temp = 8'h50;
      measure();
      chk("overtemp hold", therm_n, 1'b0);
      rd_chk(ADDR_THST, 8'h04);
      ch_in[2].temp = 8'h40;
      measure();
      chk("overtemp release", therm_n, 1'b1);
      wr_reg(ADDR_CFG, 8'h01);
      temp1 = 8'h50;
      measure();
      rd_chk(ADDR_HIST, 8'h02);
      repeat (4) @(negedge clk_i);
      chk("comparator hold", alert_n, 1'b0);
      temp1 = 8'h40;
      measure();
      chk("comparator hyst", alert_n, 1'b0);
      temp1 = 8'h05;
      measure();
      chk("comparator low", alert_n, 1'b1);
      rd_chk(ADDR_LOST, 8'h02);
      kind = 3'h1;
      measure();
      chk("comparator fault", alert_n, 1'b1);
      rd_chk(ADDR_FLST, 8'h02);
      rst_i = 1'b1;
      @(negedge clk_i);
      chk("reset pins", {therm_n, alert_n}, 2'b11);
      chk("reset result", res[2], 8'h00);
      chk("reset rdata", rdata, 8'h00);
      rst_i = 1'b0;
      kind = 3'h0;
      repeat (2) @(negedge clk_i);
      chk("reset factor", fac[3], 16'h2760);
      rd_chk(ADDR_CONSEC, 8'h70);
      rd_chk(ADDR_CFG, 8'h00);
      conclude();
   end
endmodule
